// File: tmc_pkg.sv
// Shared constants, encodings and carriers for the timer module core
package tmc_pkg;

  // Counter geometry
  localparam int          CNT_W      = 10;
  localparam int          PER_W      = 3;
  localparam int          PER_LSB_W  = CNT_W - PER_W;
  localparam int          NUM_CMP    = 3;

  // Comparator and pending flag positions
  localparam int          IDX_A      = 0;
  localparam int          IDX_B      = 1;
  localparam int          IDX_P      = 2;

  // Values after reset
  localparam logic [CNT_W-1:0]   CNT_RST  = 10'h000;
  localparam logic [NUM_CMP-1:0] PEND_RST = 3'h0;
  localparam logic               CH_RST   = 1'h0;
  localparam logic               PIN_RST  = 1'h0;

  // Clock source selection codes
  localparam logic [2:0] CKS_SYS_DIV4 = 3'h0;
  localparam logic [2:0] CKS_SYS      = 3'h1;
  localparam logic [2:0] CKS_HS_DIV16 = 3'h2;
  localparam logic [2:0] CKS_HS_DIV64 = 3'h3;
  localparam logic [2:0] CKS_TBC      = 3'h4;
  localparam logic [2:0] CKS_RSVD     = 3'h5;
  localparam logic [2:0] CKS_EXT_A    = 3'h6;
  localparam logic [2:0] CKS_EXT_B    = 3'h7;

  // Prescaler terminal counts, prescaler and synchroniser reset values
  localparam logic [1:0] SYS_DIV4_LAST  = 2'h3;
  localparam logic [5:0] HS_DIV16_LAST  = 6'h0F;
  localparam logic [5:0] HS_DIV64_LAST  = 6'h3F;
  localparam logic [1:0] DIV4_RST       = 2'h0;
  localparam logic [5:0] HSDIV_RST      = 6'h00;
  localparam logic [2:0] SYNC_RST       = 3'h0;

  typedef enum logic [1:0] {
    TMC_MODE_CMP = 2'h0,
    TMC_MODE_TMR = 2'h1,
    TMC_MODE_PWM = 2'h2,
    TMC_MODE_RES = 2'h3
  } tmc_mode_t;

  typedef enum logic [1:0] {
    TMC_ACT_NONE   = 2'h0,
    TMC_ACT_LOW    = 2'h1,
    TMC_ACT_HIGH   = 2'h2,
    TMC_ACT_TOGGLE = 2'h3
  } tmc_act_t;

  typedef enum logic [1:0] {
    TMC_ST_STOP = 2'b01,
    TMC_ST_RUN  = 2'b10
  } tmc_state_t;

  typedef struct packed {
    logic [2:0]       clkSel;
    logic             extFalling;
    logic             timerOn;
    tmc_mode_t        mode;
    logic             clrOnA;
    tmc_act_t         actA;
    tmc_act_t         actB;
    logic [CNT_W-1:0] cmpA;
    logic [CNT_W-1:0] cmpB;
    logic [PER_W-1:0] cmpP;
  } tmc_cfg_t;

endpackage

// File: tmc_clk_sel.sv
// Counter clock source selection, prescalers and external pin edge detect
`timescale 1ns/100ps
`default_nettype none
module tmc_clk_sel (
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic [2:0] clkSel,
  input  wire logic       extFalling,
  input  wire logic       hsTick,
  input  wire logic       tbTick,
  input  wire logic       extPin,
  output logic            cntTick
);

  logic [1:0] div4_ff;
  logic [1:0] nxt_div4;
  logic [5:0] hsDiv_ff;
  logic [5:0] nxt_hsDiv;
  logic [2:0] extSync_ff;
  logic [2:0] nxt_extSync;
  logic       extLvl_ff;
  logic       nxt_extLvl;
  logic       tick_ff;
  logic       nxt_tick;
  logic       extEdge;

  always_comb begin
    nxt_div4    = div4_ff + 2'h1;
    nxt_hsDiv   = hsTick ? hsDiv_ff + 6'h01 : hsDiv_ff;
    nxt_extSync = {extSync_ff[1:0], extPin};
    // A new pin level counts once the second and third stages agree
    nxt_extLvl  = (extSync_ff[1] == extSync_ff[2]) ? extSync_ff[2]
                                                   : extLvl_ff;
    extEdge     = (nxt_extLvl != extLvl_ff) &&
                  (nxt_extLvl == ~extFalling); // RQ8
    case (clkSel) // RQ1
      tmc_pkg::CKS_SYS_DIV4: nxt_tick = (div4_ff == tmc_pkg::SYS_DIV4_LAST);
      tmc_pkg::CKS_SYS:      nxt_tick = 1'b1;
      tmc_pkg::CKS_HS_DIV16: nxt_tick = hsTick &&
                             (hsDiv_ff[3:0] == tmc_pkg::HS_DIV16_LAST[3:0]);
      tmc_pkg::CKS_HS_DIV64: nxt_tick = hsTick &&
                             (hsDiv_ff == tmc_pkg::HS_DIV64_LAST);
      tmc_pkg::CKS_TBC:      nxt_tick = tbTick;
      tmc_pkg::CKS_RSVD:     nxt_tick = 1'b0; // RQ2
      default:               nxt_tick = extEdge; // RQ7
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      div4_ff    <= tmc_pkg::DIV4_RST;
      hsDiv_ff   <= tmc_pkg::HSDIV_RST;
      extSync_ff <= tmc_pkg::SYNC_RST;
      extLvl_ff  <= 1'b0;
      tick_ff    <= 1'b0;
    end else begin
      div4_ff    <= nxt_div4;
      hsDiv_ff   <= nxt_hsDiv;
      extSync_ff <= nxt_extSync;
      extLvl_ff  <= nxt_extLvl;
      tick_ff    <= nxt_tick;
    end
  end

  assign cntTick = tick_ff;

endmodule // tmc_clk_sel
`default_nettype wire

// File: tmc_cmp.sv
// Equality comparator that fires only when the counter has just advanced
`timescale 1ns/100ps
`default_nettype none
module tmc_cmp #(
  parameter int W = 10
) (
  input  wire logic [W-1:0] count,
  input  wire logic [W-1:0] value,
  input  wire logic         advanced,
  input  wire logic         present,
  output logic              match
);

  always_comb begin
    match = present && advanced && (count == value); // RQ3
  end

endmodule // tmc_cmp
`default_nettype wire

// File: tmc_core.sv
// Timer module core: counter, comparators, output channels and pin muxing
//
// Notes on behaviour
// [RQ1] A three-bit field picks system, high-speed, time-base or pin clock.
// [RQ2] The reserved clock code feeds no clock, so the counter stops.
// [RQ3] Counter is compared with each comparator; equality raises a request.
// [RQ4] A compare match can clear the counter and change the output pin.
// [RQ5] Compact and standard variants have separate A and P match interrupts.
// [RQ6] Enhanced variant has comparators A, B and P, each with an interrupt.
// [RQ7] The external input pin drives the counter only when selected.
// [RQ8] Software picks rising or falling active edge of the external input.
// [RQ9] In compare output mode a channel goes high, low or toggles on match.
// [RQ10] The PWM waveform appears on the timer output pin.
// [RQ11] A pin shows timer output only when its enable bit is set.
// [RQ12] Per-pin inversion bits give complementary waveforms on several pins.
// [RQ13] Counter increments once per active clock edge and wraps to zero.
// [RQ14] Each match latches a pending flag held until software clears it.
`timescale 1ns/100ps
`default_nettype none
module tmc_core #(
  parameter int NPINS = 2,
  parameter bit HAS_B = 1'b0
) (
  input  wire logic                      core_clk,
  input  wire logic                      resetn,
  input  wire tmc_pkg::tmc_cfg_t         cfg,
  input  wire logic                      hsTick,
  input  wire logic                      tbTick,
  input  wire logic                      extPin,
  input  wire logic [tmc_pkg::NUM_CMP-1:0] pendClr,
  input  wire logic [NPINS-1:0]          pinEnable,
  input  wire logic [NPINS-1:0]          pinInvert,
  input  wire logic [NPINS-1:0]          pinSrcB,
  input  wire logic [NPINS-1:0]          altOut,
  output logic [tmc_pkg::CNT_W-1:0]      count,
  output logic [tmc_pkg::NUM_CMP-1:0]    pend,
  output logic [tmc_pkg::NUM_CMP-1:0]    matchPulse,
  output logic                           running,
  output logic [NPINS-1:0]               pinOut
);

  localparam logic [tmc_pkg::PER_LSB_W-1:0] PER_LSB_ZERO = '0;

  // Control state
  tmc_pkg::tmc_state_t               state_ff;
  tmc_pkg::tmc_state_t               nxt_state;
  logic                              startClr;
  logic                              running_ff;
  logic                              nxt_running;

  // Counter state
  logic [tmc_pkg::CNT_W-1:0]         count_ff;
  logic [tmc_pkg::CNT_W-1:0]         nxt_count;
  logic                              adv_ff;
  logic                              nxt_adv;
  logic                              cntTick;
  logic                              clrHit;
  logic [tmc_pkg::CNT_W-1:0]         perValue;

  // Match, flag and channel state
  logic [tmc_pkg::NUM_CMP-1:0]       match;
  logic [tmc_pkg::NUM_CMP-1:0]       cmpPresent;
  logic [tmc_pkg::NUM_CMP-1:0]       pend_ff;
  logic [tmc_pkg::NUM_CMP-1:0]       nxt_pend;
  logic [tmc_pkg::NUM_CMP-1:0]       mPulse_ff;
  logic [tmc_pkg::NUM_CMP-1:0]       nxt_mPulse;
  logic                              chA_ff;
  logic                              nxt_chA;
  logic                              chB_ff;
  logic                              nxt_chB;
  logic                              periodStart;

  // Pin state
  logic [NPINS-1:0]                  pin_ff;
  logic [NPINS-1:0]                  nxt_pin;

  tmc_clk_sel u_clk_sel (
    .core_clk   (core_clk),
    .resetn     (resetn),
    .clkSel     (cfg.clkSel),
    .extFalling (cfg.extFalling),
    .hsTick     (hsTick),
    .tbTick     (tbTick),
    .extPin     (extPin),
    .cntTick    (cntTick)
  );

  // Comparator P checks the whole counter against cmpP followed by seven zero bits
  assign perValue = {cfg.cmpP, PER_LSB_ZERO};

  // Comparator B exists only in the enhanced variant
  assign cmpPresent = {1'b1, HAS_B, 1'b1}; // RQ5 RQ6

  tmc_cmp #(
    .W (tmc_pkg::CNT_W)
  ) u_cmp_a (
    .count    (count_ff),
    .value    (cfg.cmpA),
    .advanced (adv_ff),
    .present  (cmpPresent[tmc_pkg::IDX_A]),
    .match    (match[tmc_pkg::IDX_A])
  );

  tmc_cmp #(
    .W (tmc_pkg::CNT_W)
  ) u_cmp_b (
    .count    (count_ff),
    .value    (cfg.cmpB),
    .advanced (adv_ff),
    .present  (cmpPresent[tmc_pkg::IDX_B]),
    .match    (match[tmc_pkg::IDX_B])
  );

  tmc_cmp #(
    .W (tmc_pkg::CNT_W)
  ) u_cmp_p (
    .count    (count_ff),
    .value    (perValue),
    .advanced (adv_ff),
    .present  (cmpPresent[tmc_pkg::IDX_P]),
    .match    (match[tmc_pkg::IDX_P])
  );

  // Run control: turning the timer on clears the counter
  always_comb begin
    nxt_state = state_ff;
    startClr  = 1'b0;
    case (state_ff)
      tmc_pkg::TMC_ST_STOP: begin
        if (cfg.timerOn) begin
          nxt_state = tmc_pkg::TMC_ST_RUN;
          startClr  = 1'b1;
        end
      end
      tmc_pkg::TMC_ST_RUN: begin
        if (!cfg.timerOn) begin
          nxt_state = tmc_pkg::TMC_ST_STOP;
        end
      end
      default: begin
        nxt_state = tmc_pkg::TMC_ST_STOP;
      end
    endcase
    // Run flag is registered so the output comes straight from a flip-flop
    nxt_running = (nxt_state == tmc_pkg::TMC_ST_RUN);
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state_ff   <= tmc_pkg::TMC_ST_STOP;
      running_ff <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      running_ff <= nxt_running;
    end
  end

  // Counter: the tick that leaves the clear value returns it to zero
  always_comb begin
    if (cfg.clrOnA && (cfg.mode != tmc_pkg::TMC_MODE_PWM)) begin
      clrHit = (count_ff == cfg.cmpA); // RQ4
    end else begin
      // A zero period field means the full count range
      clrHit = (cfg.cmpP != 3'h0) && (count_ff == perValue); // RQ4
    end
    nxt_count = count_ff;
    nxt_adv   = 1'b0;
    if (startClr) begin
      nxt_count = tmc_pkg::CNT_RST;
    end else if ((state_ff == tmc_pkg::TMC_ST_RUN) && cntTick) begin
      nxt_adv = 1'b1;
      if (clrHit) begin
        nxt_count = tmc_pkg::CNT_RST; // RQ4
      end else begin
        nxt_count = count_ff + 10'h001; // RQ13
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      count_ff <= tmc_pkg::CNT_RST;
      adv_ff   <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      adv_ff   <= nxt_adv;
    end
  end

  // Pending flags: a new match wins over a clear in the same cycle
  always_comb begin
    nxt_pend = (pend_ff & ~pendClr) | match; // RQ14 RQ3
  end

  // Output channels A and B
  assign periodStart = adv_ff && (count_ff == tmc_pkg::CNT_RST);

  function automatic logic applyAct(input tmc_pkg::tmc_act_t act,
                                    input logic             cur);
    case (act)
      tmc_pkg::TMC_ACT_LOW:    applyAct = 1'b0;
      tmc_pkg::TMC_ACT_HIGH:   applyAct = 1'b1;
      tmc_pkg::TMC_ACT_TOGGLE: applyAct = ~cur;
      default:                 applyAct = cur;
    endcase
  endfunction

  always_comb begin
    nxt_chA = chA_ff;
    nxt_chB = chB_ff;
    case (cfg.mode)
      tmc_pkg::TMC_MODE_CMP: begin
        if (match[tmc_pkg::IDX_A]) begin
          nxt_chA = applyAct(cfg.actA, chA_ff); // RQ9 RQ4
        end
        if (match[tmc_pkg::IDX_B]) begin
          nxt_chB = applyAct(cfg.actB, chB_ff); // RQ9 RQ4
        end
      end
      tmc_pkg::TMC_MODE_PWM: begin
        // High from the period start until the duty match
        if (match[tmc_pkg::IDX_A]) begin
          nxt_chA = 1'b0; // RQ10
        end else if (periodStart) begin
          nxt_chA = 1'b1; // RQ10
        end
        if (match[tmc_pkg::IDX_B]) begin
          nxt_chB = 1'b0; // RQ10
        end else if (periodStart && HAS_B) begin
          nxt_chB = 1'b1; // RQ10
        end
      end
      default: begin
        nxt_chA = chA_ff;
        nxt_chB = chB_ff;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pend_ff <= tmc_pkg::PEND_RST;
    end else begin
      pend_ff <= nxt_pend;
    end
  end

  // Match pulses leave one cycle late, in step with the pending flags
  always_comb begin
    nxt_mPulse = match; // RQ3
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      mPulse_ff <= tmc_pkg::PEND_RST;
    end else begin
      mPulse_ff <= nxt_mPulse;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      chA_ff <= tmc_pkg::CH_RST;
      chB_ff <= tmc_pkg::CH_RST;
    end else begin
      chA_ff <= nxt_chA;
      chB_ff <= nxt_chB;
    end
  end

  // Pin muxing: timer channel, optionally inverted, or the alternate function
  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi++) begin : g_pin
      logic chSel;
      assign chSel = (pinSrcB[gi] && HAS_B) ? chB_ff : chA_ff;
      // RQ11 RQ12
      assign nxt_pin[gi] = pinEnable[gi] ? (chSel ^ pinInvert[gi])
                                         : altOut[gi];
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pin_ff <= {NPINS{tmc_pkg::PIN_RST}};
    end else begin
      pin_ff <= nxt_pin;
    end
  end

  assign count      = count_ff;
  assign pend       = pend_ff;
  assign matchPulse = mPulse_ff;
  assign running    = running_ff;
  assign pinOut     = pin_ff;

endmodule // tmc_core
`default_nettype wire

// File: tmc_core_properties.sv
// Concurrent checks on the timer core ports
`timescale 1ns/100ps
`default_nettype none
module tmc_core_chk #(
  parameter int NPINS = 2,
  parameter bit HAS_B = 1'b0
) (
  input wire logic                           core_clk,
  input wire logic                           resetn,
  input wire tmc_pkg::tmc_cfg_t              cfg,
  input wire logic                           hsTick,
  input wire logic                           tbTick,
  input wire logic                           extPin,
  input wire logic [tmc_pkg::NUM_CMP-1:0]    pendClr,
  input wire logic [NPINS-1:0]               pinEnable,
  input wire logic [NPINS-1:0]               pinInvert,
  input wire logic [NPINS-1:0]               pinSrcB,
  input wire logic [NPINS-1:0]               altOut,
  input wire logic [tmc_pkg::CNT_W-1:0]      count,
  input wire logic [tmc_pkg::NUM_CMP-1:0]    pend,
  input wire logic [tmc_pkg::NUM_CMP-1:0]    matchPulse,
  input wire logic                           running,
  input wire logic [NPINS-1:0]               pinOut
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  start_clears_a: assert property ($rose(cfg.timerOn) |=>
    running && count == tmc_pkg::CNT_RST) else $error("start did not clear");
  stop_holds_a: assert property ((!cfg.timerOn)[*3] |->
    !running && $stable(count)) else $error("stopped counter moved");
  rsvd_stops_a: assert property (
    (cfg.clkSel == tmc_pkg::CKS_RSVD && cfg.timerOn)[*4] |-> $stable(count))
    else $error("reserved source advanced counter");
  match_a_a: assert property (matchPulse[tmc_pkg::IDX_A] |->
    $past(count) == $past(cfg.cmpA)) else $error("bad A match");
  match_p_a: assert property (matchPulse[tmc_pkg::IDX_P] |->
    $past(count) == {$past(cfg.cmpP), 7'h00}) else $error("bad P match");
  no_b_a: assert property (!HAS_B |->
    !matchPulse[tmc_pkg::IDX_B] && !pend[tmc_pkg::IDX_B])
    else $error("B source active without comparator B");
  pend_set_a: assert property (matchPulse[tmc_pkg::IDX_A] |->
    pend[tmc_pkg::IDX_A]) else $error("pending not set");
  pend_hold_a: assert property (
    pend[tmc_pkg::IDX_A] && !pendClr[tmc_pkg::IDX_A] |=> pend[tmc_pkg::IDX_A])
    else $error("pending lost");
  pin_toggle_a: assert property (matchPulse[0] && cfg.actA ==
    tmc_pkg::TMC_ACT_TOGGLE && cfg.mode == tmc_pkg::TMC_MODE_CMP &&
    pinEnable[0] && $past(pinEnable[0]) && !pinSrcB[0] &&
    $stable(pinInvert[0]) |=> pinOut[0] != $past(pinOut[0]))
    else $error("pin did not toggle");
  alt_pin_a: assert property ($past(resetn) && !$past(pinEnable[0]) |->
    pinOut[0] == $past(altOut[0])) else $error("alternate not routed");
  compl_pins_a: assert property ($past(resetn) &&
    $past(pinEnable[1:0] == 2'h3 && pinSrcB[1:0] == 2'h0 &&
    pinInvert[1:0] == 2'h2) |-> pinOut[0] != pinOut[1])
    else $error("pins not complementary");
endmodule // tmc_core_chk

bind tmc_core tmc_core_chk #(.NPINS(NPINS), .HAS_B(HAS_B)) i_tmc_core_chk (
  .core_clk(core_clk), .resetn(resetn), .cfg(cfg), .hsTick(hsTick),
  .tbTick(tbTick), .extPin(extPin), .pendClr(pendClr),
  .pinEnable(pinEnable), .pinInvert(pinInvert), .pinSrcB(pinSrcB),
  .altOut(altOut), .count(count), .pend(pend), .matchPulse(matchPulse),
  .running(running), .pinOut(pinOut));
`default_nettype wire

// File: tmc_ext_src.sv
// External event source: bursts of pulses, each level held four cycles
`timescale 1ns/100ps
`default_nettype none
module tmc_ext_src (
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic       go,
  input  wire logic [7:0] nPulses,
  output logic            busy,
  output logic            extPin
);
  logic [7:0] left;
  logic [2:0] ph;
  // Pin rests low between bursts so no stray edge reaches the counter
  always @(posedge core_clk) begin
    if (!resetn) begin
      left <= 8'h00;
      ph <= 3'h0;
      extPin <= 1'h0;
    end else if (go && left == 8'h00) begin
      left <= nPulses;
      ph <= 3'h0;
    end else if (left != 8'h00) begin
      ph <= ph + 3'h1;
      if (ph == 3'h3) extPin <= 1'h1;
      if (ph == 3'h7) begin
        extPin <= 1'h0;
        left <= left - 8'h01;
      end
    end
  end
  assign busy = (left != 8'h00);
endmodule // tmc_ext_src
`default_nettype wire

// File: tb_timer_module_common_core.sv
// Self-checking testbench for the timer core
`timescale 1ns/100ps
`default_nettype none
module tb_timer_module_common_core;
  logic              core_clk, resetn, hsTick, tbTick, go, running, busy;
  logic              extPin;
  tmc_pkg::tmc_cfg_t cfg;
  logic [2:0]        pendClr, pend, matchPulse;
  logic [1:0]        pinEnable, pinInvert, pinSrcB, altOut, pinOut;
  logic [7:0]        nPulses;
  logic [9:0]        count;
  int                n_fail = 0;
  int                total_checks = 0;

  tmc_core i_tmc_core (.core_clk(core_clk), .resetn(resetn), .cfg(cfg),
    .hsTick(hsTick), .tbTick(tbTick), .extPin(extPin), .pendClr(pendClr),
    .pinEnable(pinEnable), .pinInvert(pinInvert), .pinSrcB(pinSrcB),
    .altOut(altOut), .count(count), .pend(pend), .matchPulse(matchPulse),
    .running(running), .pinOut(pinOut));
  tmc_ext_src i_tmc_ext_src (.core_clk(core_clk), .resetn(resetn), .go(go),
    .nPulses(nPulses), .busy(busy), .extPin(extPin));

  always #12.5 core_clk = ~core_clk;
  always @(negedge core_clk) begin
    hsTick <= ~hsTick;
    tbTick <= ~tbTick;
  end

  task automatic chk(input logic [9:0] got, input logic [9:0] exp,
                     input string what);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what,
               got, exp);
    end
  endtask

  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic wait_a;
    for (int k = 0; k < 40 && matchPulse[0] !== 1'b1; k++) cyc(1);
    chk(matchPulse[0], 1, "A match seen");
  endtask

  task automatic t_rates;
    logic [9:0] rate [6] = '{10'h020, 10'h080, 10'h004, 10'h001, 10'h040, 0};
    logic [9:0] c0;
    cfg.mode = tmc_pkg::TMC_MODE_TMR;
    cfg.timerOn = 1'b1;
    for (int s = 0; s < 6; s++) begin
      cfg.clkSel = s[2:0];
      cyc(8);
      c0 = count;
      cyc(128);
      chk(count - c0, rate[s], "advance per source");
    end
  endtask

  task automatic t_ext;
    logic [2:0] sel [3] = '{3'h6, 3'h7, 3'h5};
    logic       fall [3] = '{1'b0, 1'b1, 1'b0};
    logic [9:0] exp [3] = '{10'h003, 10'h003, 10'h000};
    logic [9:0] c0;
    for (int i = 0; i < 3; i++) begin
      cfg.clkSel = sel[i];
      cfg.extFalling = fall[i];
      cyc(8);
      c0 = count;
      nPulses = 8'h03;
      go = 1'b1;
      cyc(1);
      go = 1'b0;
      for (int k = 0; k < 200 && busy; k++) cyc(1);
      cyc(8);
      chk(count - c0, exp[i], "external edges");
    end
  endtask

  task automatic t_cmp;
    tmc_pkg::tmc_act_t act [5] = '{tmc_pkg::TMC_ACT_HIGH,
      tmc_pkg::TMC_ACT_LOW, tmc_pkg::TMC_ACT_TOGGLE,
      tmc_pkg::TMC_ACT_TOGGLE, tmc_pkg::TMC_ACT_NONE};
    logic lvl [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    int gap;
    cfg.mode = tmc_pkg::TMC_MODE_CMP;
    cfg.clkSel = tmc_pkg::CKS_SYS;
    cfg.clrOnA = 1'b1;
    cfg.cmpA = 10'h00A;
    // Restart so the count starts below the clear value
    cfg.timerOn = 1'b0;
    cyc(2);
    cfg.timerOn = 1'b1;
    pinEnable = 2'h3;
    pinInvert = 2'h2;
    for (int i = 0; i < 5; i++) begin
      cfg.actA = act[i];
      wait_a;
      cyc(2);
      chk(pinOut[0], lvl[i], "pin action");
      chk(!pinOut[1], lvl[i], "inverted pin");
    end
    wait_a;
    gap = 0;
    cyc(1);
    while (matchPulse[0] !== 1'b1 && gap < 40) begin
      gap++;
      cyc(1);
    end
    chk(10'(gap), 10'h00A, "match period");
    chk(pend[0], 1, "pending set");
    pendClr = 3'h1;
    cyc(1);
    pendClr = 3'h0;
    cyc(1);
    chk(pend[0], 0, "pending cleared");
  endtask

  task automatic t_pwm;
    int   hi0 = 0;
    int   hi1 = 0;
    logic seenP = 1'b0;
    cfg.mode = tmc_pkg::TMC_MODE_PWM;
    cfg.cmpA = 10'h020;
    cfg.cmpP = 3'h1;
    cyc(300);
    repeat (129) begin
      cyc(1);
      hi0 += pinOut[0];
      hi1 += pinOut[1];
      seenP |= matchPulse[2];
    end
    chk(10'(hi0), 10'h020, "duty high");
    chk(10'(hi1), 10'h061, "inverted duty");
    chk(seenP, 1, "P match");
    pinEnable = 2'h0;
    altOut = 2'h1;
    cyc(3);
    chk(pinOut, 10'h001, "alternate function");
  endtask

  initial begin
    core_clk = 1'b0;
    resetn = 1'b0;
    cfg = '0;
    hsTick = 1'b0;
    tbTick = 1'b0;
    go = 1'b0;
    nPulses = 8'h00;
    pendClr = 3'h0;
    pinEnable = 2'h0;
    pinInvert = 2'h0;
    pinSrcB = 2'h0;
    altOut = 2'h0;
    cyc(4);
    chk({count, pend, running, pinOut} == 0, 1, "reset values");
    resetn = 1'b1;
    cyc(1);
    t_rates;
    t_ext;
    t_cmp;
    t_pwm;
    complete_run;
  end

  initial begin
    repeat (5000) @(posedge core_clk);
    n_fail++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    complete_run;
  end
endmodule // tb_timer_module_common_core
`default_nettype wire
